// ---- logic/nvm_loader_pkg.sv ----
// constants and types for the reset, initialization and non-volatile loader
package nvm_loader_pkg;

  // register addresses and fields
  localparam logic [15:0] SOFT_RST_ADDR = 16'h001c;
  localparam int SOFT_RST_BIT = 0;
  localparam logic [15:0] HARD_RST_ADDR = 16'h001e;
  localparam int HARD_RST_BIT = 1;
  localparam logic [15:0] BANK_ADDR = 16'h00e2;
  localparam logic [15:0] PROG_ADDR = 16'h00e3;
  localparam logic [15:0] RELOAD_ADDR = 16'h00e4;
  localparam int RELOAD_BIT = 0;
  localparam logic [15:0] READY_ADDR = 16'h00fe;
  localparam logic [15:0] CFG_BASE = 16'h0100;

  // register values
  localparam logic [7:0] PROG_KEY = 8'hc7;
  localparam logic [7:0] READY_VAL = 8'h0f;
  localparam logic [7:0] BUSY_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;

  // configuration store: one factory bank plus two programmable banks
  localparam int CFG_N = 4;
  localparam int NVM_BANKS = 3;
  localparam logic [1:0] PROG_LIMIT = 2'h2;
  localparam logic [1:0] LAST_IDX = 2'h3;
  localparam logic [31:0] CFG_DEFAULT = 32'h0000_0000;
  localparam logic [5:0] BANK_IND0 = 6'h03;
  localparam logic [5:0] BANK_IND1 = 6'h0f;
  localparam logic [5:0] BANK_IND2 = 6'h3f;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int NVM_BYTE_PROG_NS = 1000;
  localparam int SOFT_RST_NS = 100;
  localparam int PROG_BYTE_CYC = (NVM_BYTE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {ST_INIT, ST_RUN, ST_PROG, ST_LOAD, ST_SOFT} state_e;

endpackage : nvm_loader_pkg

// ---- logic/reset_init_nvm_loader.sv ----
// power-up initialization, hard and soft reset, and in-circuit programming of the configuration store
// Notes on behaviour
// - after power-up, load register defaults from the nonvolatile store before normal operation
// - output clocks stay inactive until initialization has finished
// - serial port takes transactions only after initialization; host waits for that
// - hard reset acts like power-up: reload from store, serial port reinitialized
// - hard reset starts from the reset pin or the hard reset control bit
// - soft reset bit applies settings without reloading from the store
// - store takes two programming cycles only; the old configuration becomes unreachable
// - writing 0xC7 to the program command register stores current configuration
// - eight-bit ready register tells whether the serial port accepts commands
// - writing one to the reload bit reloads registers from the stored contents
// - six-bit read-only field names the active bank of the store
`timescale 1ns/1ps
`default_nettype none

module reset_init_nvm_loader (
  // clock, power-on reset, clock enable
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // hard reset pin
  input wire logic RESET_PIN_N,
  // register access from the serial port decoder
  input wire logic [15:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // clock path control, serial ready flag and configuration
  output logic CLK_OUT_EN,
  output logic SOFT_RST_OUT,
  output logic SERIAL_READY,
  output logic [31:0] CFG_OUT
);

  nvm_loader_pkg::state_e st_q, st_d;
  logic [1:0] idx_q, idx_d;
  logic [5:0] wait_q, wait_d;
  logic [1:0] bank_q, bank_d;
  logic [nvm_loader_pkg::CFG_N-1:0][7:0] cfg_q, cfg_d;
  logic [nvm_loader_pkg::NVM_BANKS-1:0][nvm_loader_pkg::CFG_N-1:0][7:0] nvm_q, nvm_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic oen_q, oen_d;
  logic soft_q, soft_d;
  logic ready_q, ready_d;
  logic hard;
  logic wr_ok;
  logic in_cfg;
  logic [15:0] cfg_off;
  logic [5:0] bank_ind;

  // bank codes are arbitrary, chosen only to be distinct
  always_comb begin
    case (bank_q)
      2'h0: bank_ind = nvm_loader_pkg::BANK_IND0;
      2'h1: bank_ind = nvm_loader_pkg::BANK_IND1;
      default: bank_ind = nvm_loader_pkg::BANK_IND2;
    endcase
  end

  assign cfg_off = REG_ADDR - nvm_loader_pkg::CFG_BASE;
  assign in_cfg = (REG_ADDR >= nvm_loader_pkg::CFG_BASE) &&
                  (cfg_off < 16'(nvm_loader_pkg::CFG_N));
  // writes only land while the port reports ready
  assign wr_ok = REG_WR && ready_q;

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    wait_d = wait_q;
    bank_d = bank_q;
    cfg_d = cfg_q;
    nvm_d = nvm_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    hard = !RESET_PIN_N;

    // reads: nothing answers during initialization; while busy every address answers, all with 0x00
    if (REG_RD && (st_q != nvm_loader_pkg::ST_INIT)) begin
      rvalid_d = 1'b1;
      if (REG_ADDR == nvm_loader_pkg::READY_ADDR) begin
        rdata_d = ready_q ? nvm_loader_pkg::READY_VAL : nvm_loader_pkg::BUSY_VAL;
      end else if (!ready_q) begin
        rdata_d = nvm_loader_pkg::BUSY_VAL;
      end else if (REG_ADDR == nvm_loader_pkg::BANK_ADDR) begin
        rdata_d = {2'h0, bank_ind};
      end else if (in_cfg) begin
        rdata_d = cfg_q[cfg_off[1:0]];
      end else begin
        rdata_d = nvm_loader_pkg::UNMAPPED_VAL;
      end
    end

    case (st_q)
      nvm_loader_pkg::ST_INIT, nvm_loader_pkg::ST_LOAD: begin
        // one byte per cycle out of the active bank
        cfg_d[idx_q] = nvm_q[bank_q][idx_q];
        if (idx_q == nvm_loader_pkg::LAST_IDX) begin
          idx_d = 2'h0;
          st_d = nvm_loader_pkg::ST_RUN;
        end else begin
          idx_d = idx_q + 2'h1;
        end
      end
      nvm_loader_pkg::ST_PROG: begin
        if (wait_q == 6'h00) begin
          nvm_d[2'(bank_q + 2'h1)][idx_q] = cfg_q[idx_q];
          if (idx_q == nvm_loader_pkg::LAST_IDX) begin
            // switching banks leaves the previous image unreachable
            bank_d = bank_q + 2'h1;
            idx_d = 2'h0;
            st_d = nvm_loader_pkg::ST_RUN;
          end else begin
            idx_d = idx_q + 2'h1;
            wait_d = 6'(nvm_loader_pkg::PROG_BYTE_CYC - 1);
          end
        end else begin
          wait_d = wait_q - 6'h01;
        end
      end
      nvm_loader_pkg::ST_SOFT: begin
        if (wait_q == 6'h00) begin
          st_d = nvm_loader_pkg::ST_RUN;
        end else begin
          wait_d = wait_q - 6'h01;
        end
      end
      default: begin
        if (wr_ok) begin
          if (REG_ADDR == nvm_loader_pkg::HARD_RST_ADDR) begin
            hard = REG_WDATA[nvm_loader_pkg::HARD_RST_BIT] || !RESET_PIN_N;
          end else if (REG_ADDR == nvm_loader_pkg::SOFT_RST_ADDR) begin
            if (REG_WDATA[nvm_loader_pkg::SOFT_RST_BIT]) begin
              // configuration is left as it is; only the datapath is pulsed
              st_d = nvm_loader_pkg::ST_SOFT;
              wait_d = 6'(nvm_loader_pkg::SOFT_RST_CYC - 1);
            end
          end else if (REG_ADDR == nvm_loader_pkg::PROG_ADDR) begin
            // a used-up store silently ignores further program commands
            if (REG_WDATA == nvm_loader_pkg::PROG_KEY && bank_q < nvm_loader_pkg::PROG_LIMIT) begin
              st_d = nvm_loader_pkg::ST_PROG;
              idx_d = 2'h0;
              wait_d = 6'(nvm_loader_pkg::PROG_BYTE_CYC - 1);
            end
          end else if (REG_ADDR == nvm_loader_pkg::RELOAD_ADDR) begin
            if (REG_WDATA[nvm_loader_pkg::RELOAD_BIT]) begin
              st_d = nvm_loader_pkg::ST_LOAD;
              idx_d = 2'h0;
            end
          end else if (in_cfg) begin
            cfg_d[cfg_off[1:0]] = REG_WDATA;
          end
        end
      end
    endcase

    // hard reset throws away any transfer in flight, the store itself survives
    if (hard) begin
      st_d = nvm_loader_pkg::ST_INIT;
      idx_d = 2'h0;
      wait_d = 6'h00;
      cfg_d = '0;
      nvm_d = nvm_q;
      bank_d = bank_q;
      rdata_d = 8'h00;
      rvalid_d = 1'b0;
    end

    oen_d = (st_d != nvm_loader_pkg::ST_INIT);
    soft_d = (st_d == nvm_loader_pkg::ST_SOFT);
    // ready drops during soft reset too: a write taken there would be lost while the datapath restarts
    ready_d = (st_d == nvm_loader_pkg::ST_RUN);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_q <= nvm_loader_pkg::ST_INIT;
      idx_q <= 2'h0;
      wait_q <= 6'h00;
      bank_q <= 2'h0;
      cfg_q <= '0;
      nvm_q <= {64'h0, nvm_loader_pkg::CFG_DEFAULT};
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      oen_q <= 1'b0;
      soft_q <= 1'b0;
      ready_q <= 1'b0;
    end else if (CLK_EN) begin
      st_q <= st_d;
      idx_q <= idx_d;
      wait_q <= wait_d;
      bank_q <= bank_d;
      cfg_q <= cfg_d;
      nvm_q <= nvm_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      oen_q <= oen_d;
      soft_q <= soft_d;
      ready_q <= ready_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign CLK_OUT_EN = oen_q;
  assign SOFT_RST_OUT = soft_q;
  assign SERIAL_READY = ready_q;
  assign CFG_OUT = cfg_q;

  // checks
  default clocking chk_clk @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  init_load_done_a: assert property (
    (CLK_EN && !hard && st_q == nvm_loader_pkg::ST_INIT && idx_q == nvm_loader_pkg::LAST_IDX)
    |=> (cfg_q == $past(nvm_q[bank_q])) && st_q == nvm_loader_pkg::ST_RUN && CLK_OUT_EN)
    else $error("initial load did not finish with the stored image");

  clk_off_init_a: assert property (
    (st_q == nvm_loader_pkg::ST_INIT) |-> !CLK_OUT_EN)
    else $error("output clocks active during initialization");

  no_access_init_a: assert property (
    (CLK_EN && st_q == nvm_loader_pkg::ST_INIT && REG_RD) |=> !REG_RVALID)
    else $error("read answered during initialization");

  hard_reinit_a: assert property (
    (CLK_EN && hard) |=> st_q == nvm_loader_pkg::ST_INIT && idx_q == 2'h0 && !SERIAL_READY && cfg_q == '0)
    else $error("hard reset did not restart initialization");

  pin_reset_a: assert property (
    (CLK_EN && !RESET_PIN_N) |=> !CLK_OUT_EN && !REG_RVALID)
    else $error("reset pin did not start a hard reset");

  soft_keep_cfg_a: assert property (
    (CLK_EN && !hard && ready_q && st_q == nvm_loader_pkg::ST_RUN && REG_WR &&
     REG_ADDR == nvm_loader_pkg::SOFT_RST_ADDR && REG_WDATA[nvm_loader_pkg::SOFT_RST_BIT])
    |=> SOFT_RST_OUT && $stable(cfg_q) && $stable(bank_q))
    else $error("soft reset reloaded or missed");

  prog_limit_a: assert property (
    bank_q <= nvm_loader_pkg::PROG_LIMIT &&
    !(st_q == nvm_loader_pkg::ST_PROG && bank_q == nvm_loader_pkg::PROG_LIMIT))
    else $error("store programmed beyond its cycle limit");

  prog_start_a: assert property (
    (CLK_EN && !hard && ready_q && st_q == nvm_loader_pkg::ST_RUN && REG_WR &&
     REG_ADDR == nvm_loader_pkg::PROG_ADDR && REG_WDATA == nvm_loader_pkg::PROG_KEY &&
     bank_q < nvm_loader_pkg::PROG_LIMIT)
    |=> st_q == nvm_loader_pkg::ST_PROG && !SERIAL_READY)
    else $error("program command not taken");

  ready_read_a: assert property (
    (CLK_EN && !hard && REG_RD && st_q != nvm_loader_pkg::ST_INIT && REG_ADDR == nvm_loader_pkg::READY_ADDR)
    |=> REG_RVALID && (REG_RDATA == ($past(ready_q) ? nvm_loader_pkg::READY_VAL : nvm_loader_pkg::BUSY_VAL)))
    else $error("ready register read wrong");

  reload_start_a: assert property (
    (CLK_EN && !hard && ready_q && st_q == nvm_loader_pkg::ST_RUN && REG_WR &&
     REG_ADDR == nvm_loader_pkg::RELOAD_ADDR && REG_WDATA[nvm_loader_pkg::RELOAD_BIT])
    |=> st_q == nvm_loader_pkg::ST_LOAD && idx_q == 2'h0)
    else $error("reload request not taken");

  bank_read_a: assert property (
    (CLK_EN && !hard && REG_RD && ready_q && REG_ADDR == nvm_loader_pkg::BANK_ADDR)
    |=> REG_RVALID && REG_RDATA[7:6] == 2'h0 && REG_RDATA[5:0] == $past(bank_ind))
    else $error("bank indicator read wrong");

  busy_not_ready_a: assert property (
    (st_q == nvm_loader_pkg::ST_INIT || st_q == nvm_loader_pkg::ST_PROG ||
     st_q == nvm_loader_pkg::ST_LOAD) |-> !SERIAL_READY)
    else $error("ready shown while busy");

  soft_end_a: assert property (
    (CLK_EN && !hard && st_q == nvm_loader_pkg::ST_SOFT && wait_q == 6'h00)
    |=> !SOFT_RST_OUT && SERIAL_READY && st_q == nvm_loader_pkg::ST_RUN)
    else $error("soft reset pulse did not end");

  busy_write_drop_a: assert property (
    (CLK_EN && !hard && st_q == nvm_loader_pkg::ST_PROG && REG_WR) |=> $stable(cfg_q))
    else $error("write landed while busy");

  prog_store_a: assert property (
    (CLK_EN && !hard && st_q == nvm_loader_pkg::ST_PROG && wait_q == 6'h00 &&
     idx_q == nvm_loader_pkg::LAST_IDX)
    |=> nvm_q[bank_q] == $past(cfg_q) && bank_q == $past(bank_q) + 2'h1 && SERIAL_READY)
    else $error("program did not store the image in the next bank");

  reload_done_a: assert property (
    (CLK_EN && !hard && st_q == nvm_loader_pkg::ST_LOAD && idx_q == nvm_loader_pkg::LAST_IDX)
    |=> cfg_q == $past(nvm_q[bank_q]) && SERIAL_READY && CLK_OUT_EN)
    else $error("reload did not restore the stored image");

  hard_keep_store_a: assert property (
    (CLK_EN && hard) |=> $stable(nvm_q) && $stable(bank_q) && !CLK_OUT_EN)
    else $error("hard reset disturbed the store");

endmodule : reset_init_nvm_loader

`default_nettype wire

// ---- verification/host_model.sv ----
// host controller model: drives the register port the way the serial decoder would
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [15:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial begin
    addr = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end

  // each task starts one edge later, so a strobe is never lowered and raised in one time step
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    wdata = ~d;
  endtask : wr_reg

  // answer is registered on the taking edge and seen 1 ns after it; reads in initialization get none
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    v = rvalid;
    d = rdata;
  endtask : rd_reg

  // no command until ready reads 0x0f; the wait is bounded so a stuck device is seen
  task automatic poll_ready(output int n);
    logic [7:0] d;
    logic v;
    n = 0;
    do begin
      rd_reg(nvm_loader_pkg::READY_ADDR, d, v);
      n++;
    end while (!(v === 1'b1 && d === nvm_loader_pkg::READY_VAL) && n < 400);
  endtask : poll_ready
endmodule : host_model

`default_nettype wire

// ---- verification/reset_init_nvm_loader_bench.sv ----
// self-checking bench for reset, initialization and configuration store handling
`timescale 1ns/1ps
`default_nettype none

module reset_init_nvm_loader_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rst_pin_n = 1'b1;
  logic [15:0] addr;
  logic wr, rd, rvalid, clk_out_en, soft_rst, ser_rdy;
  logic [7:0] wdata, rdata, d;
  logic [31:0] cfg;
  logic v;
  int n_errors = 0;
  int n_checks = 0;
  int n;

  always #12.5 sys_clk = ~sys_clk;

  reset_init_nvm_loader dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(1'b1), .RESET_PIN_N(rst_pin_n),
    .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .CLK_OUT_EN(clk_out_en), .SOFT_RST_OUT(soft_rst), .SERIAL_READY(ser_rdy),
    .CFG_OUT(cfg));

  host_model host (.clk(sys_clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    host.rd_reg(a, d, v);
    chk({v, d}, {1'b1, exp});
  endtask : rd_chk

  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic t_init;
    host.rd_reg(nvm_loader_pkg::READY_ADDR, d, v);
    chk(v, 1'b0);
    chk(clk_out_en, 1'b0);
    @(posedge sys_clk);
    #1;
    chk(ser_rdy, 1'b0);
    @(posedge sys_clk);
    #1;
    chk({clk_out_en, ser_rdy}, 2'b11);
    rd_chk(nvm_loader_pkg::READY_ADDR, nvm_loader_pkg::READY_VAL);
    rd_chk(nvm_loader_pkg::BANK_ADDR, nvm_loader_pkg::BANK_IND0);
    chk(cfg, nvm_loader_pkg::CFG_DEFAULT);
  endtask : t_init

  task automatic t_soft;
    host.wr_reg(nvm_loader_pkg::CFG_BASE, 8'ha5);
    host.wr_reg(nvm_loader_pkg::SOFT_RST_ADDR, 8'h01);
    chk(ser_rdy, 1'b0);
    n = 0;
    repeat (8) begin
      n += int'(soft_rst === 1'b1);
      @(posedge sys_clk);
      #1;
    end
    chk(n, nvm_loader_pkg::SOFT_RST_CYC);
    chk({ser_rdy, cfg[7:0]}, {1'b1, 8'ha5});
  endtask : t_soft

  task automatic t_prog;
    host.wr_reg(nvm_loader_pkg::PROG_ADDR, 8'h55);
    rd_chk(nvm_loader_pkg::READY_ADDR, nvm_loader_pkg::READY_VAL);
    rd_chk(nvm_loader_pkg::CFG_BASE, 8'ha5);
    host.wr_reg(nvm_loader_pkg::PROG_ADDR, nvm_loader_pkg::PROG_KEY);
    rd_chk(nvm_loader_pkg::READY_ADDR, nvm_loader_pkg::BUSY_VAL);
    host.wr_reg(nvm_loader_pkg::CFG_BASE, 8'hee);
    chk(cfg[7:0], 8'ha5);
    host.poll_ready(n);
    chk(n > 1 && n < 400, 1'b1);
    rd_chk(nvm_loader_pkg::BANK_ADDR, nvm_loader_pkg::BANK_IND1);
    host.wr_reg(nvm_loader_pkg::CFG_BASE, 8'h3c);
    host.wr_reg(nvm_loader_pkg::RELOAD_ADDR, 8'h01);
    chk(ser_rdy, 1'b0);
    host.poll_ready(n);
    chk(cfg[7:0], 8'ha5);
  endtask : t_prog

  task automatic t_hard;
    host.wr_reg(nvm_loader_pkg::CFG_BASE, 8'h11);
    rst_pin_n = 1'b0;
    @(posedge sys_clk);
    #1;
    chk(clk_out_en, 1'b0);
    chk(cfg, 32'h0);
    rst_pin_n = 1'b1;
    host.poll_ready(n);
    chk({clk_out_en, cfg[7:0]}, {1'b1, 8'ha5});
    host.wr_reg(nvm_loader_pkg::HARD_RST_ADDR, 8'h02);
    chk(ser_rdy, 1'b0);
    host.poll_ready(n);
    rd_chk(nvm_loader_pkg::BANK_ADDR, nvm_loader_pkg::BANK_IND1);
  endtask : t_hard

  task automatic t_limit;
    host.wr_reg(nvm_loader_pkg::CFG_BASE + 16'h0001, 8'h77);
    host.wr_reg(nvm_loader_pkg::PROG_ADDR, nvm_loader_pkg::PROG_KEY);
    host.poll_ready(n);
    rd_chk(nvm_loader_pkg::BANK_ADDR, nvm_loader_pkg::BANK_IND2);
    host.wr_reg(nvm_loader_pkg::PROG_ADDR, nvm_loader_pkg::PROG_KEY);
    rd_chk(nvm_loader_pkg::READY_ADDR, nvm_loader_pkg::READY_VAL);
    rd_chk(nvm_loader_pkg::BANK_ADDR, nvm_loader_pkg::BANK_IND2);
    host.wr_reg(nvm_loader_pkg::CFG_BASE + 16'h0001, 8'h00);
    host.wr_reg(nvm_loader_pkg::RELOAD_ADDR, 8'h01);
    host.poll_ready(n);
    chk(cfg[15:0], 16'h77a5);
  endtask : t_limit

  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_init();
    t_soft();
    t_prog();
    t_hard();
    t_limit();
    results();
  end

  // whole run needs a few hundred cycles; this leaves ample margin
  initial begin
    #(25 * 20000);
    n_errors++;
    results();
  end
endmodule : reset_init_nvm_loader_bench

`default_nettype wire
